// ---- rtl/console_pkg.sv ----
// shared constants, register map and carrier types for the operator console
package console_pkg;

  localparam int          WORD_W        = 12;
  localparam int          KEY_W         = 6;
  localparam logic [11:0] PC_RST        = 12'h000;
  localparam logic [11:0] WORD_RST      = 12'h000;
  localparam logic [11:0] ADDR_STEP     = 12'h001;
  // guarded page: octal 7600 to 7777
  localparam logic [11:0] GUARD_LO      = 12'hF80;
  localparam logic [11:0] GUARD_HI      = 12'hFFF;
  localparam logic        GUARD_FIELD   = 1'b1;

  // register byte offsets on the bus
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_PC        = 8'h04;
  localparam logic [7:0]  REG_MA        = 8'h08;
  localparam logic [7:0]  REG_MB        = 8'h0C;
  localparam logic [7:0]  REG_AC        = 8'h10;
  localparam logic [7:0]  REG_SWITCH    = 8'h14;
  localparam logic [7:0]  REG_CTRL      = 8'h18;
  localparam logic [7:0]  REG_KEY       = 8'h1C;

  // status bit positions
  localparam int          ST_RUN_BIT    = 0;
  localparam int          ST_LOCK_BIT   = 1;
  localparam int          ST_GUARD_BIT  = 2;
  localparam int          ST_SCYC_BIT   = 3;
  localparam int          ST_SINS_BIT   = 4;
  localparam int          ST_HIT_BIT    = 5;
  localparam int          AC_LINK_BIT   = 12;
  // control bit positions
  localparam int          CT_GUARD_BIT  = 0;
  localparam int          CT_SOFT_BIT   = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;

  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_RUN  = 2'b01,
    ST_DEP  = 2'b10,
    ST_EXAMINE_KEY = 2'b11
  } con_state_t;

  typedef enum logic [1:0] {
    WR_CALL        = 2'b00,
    WR_STORE_CLEAR = 2'b01,
    WR_INC_SKIP    = 2'b10,
    WR_INPUT       = 2'b11
  } wr_kind_t;

  typedef struct packed {
    logic start;
    logic load;
    logic deposit;
    logic examine;
    logic continue_key;
    logic stop;
  } key_set_t;

  typedef struct packed {
    key_set_t    keys;
    logic        single_cycle_switch;
    logic        single_instruction_switch;
    logic        console_lockout;
    logic        top_page_write_guard;
    logic [11:0] switch_word;
  } panel_t;

  typedef struct packed {
    logic [11:0] pc;
    logic [11:0] ma;
    logic [11:0] mb;
    logic [11:0] ac;
    logic        link;
    logic        mem_cycle_done;
    logic        instr_done;
  } core_state_t;

  typedef struct packed {
    logic        valid;
    wr_kind_t    kind;
    logic        field;
    logic [11:0] addr;
  } core_wr_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [11:0] wdata;
  } mem_req_t;

endpackage : console_pkg

// ---- rtl/operator_console_control.sv ----
// operator console: panel keys, deposit/examine, run control, write guard, displays
//
// Overview of operation
// - start clears arithmetic register, link, buffer, instruction register; runs from pointer
// - load-address copies the switch word into the next-instruction pointer
// - deposit writes the switch word at the pointer's address
// - deposit advances pointer by one; address register keeps the written address
// - deposit passes the switch word through the memory buffer register
// - examine reads pointer's word into buffer and arithmetic displays, then advances
// - continue resumes at the pointer without clearing any working register
// - stop halts only after the instruction in progress completes
// - single-cycle switch: each continue runs exactly one memory cycle then halts
// - single-instruction switch: each continue runs exactly one instruction then halts, unless the single-cycle switch is also set
// - switch word is twelve toggles forming one value for loads and deposits
// - a set switch reads as one, an unset switch as zero
// - lockout ignores every key and switch except the switch word
// - write guard blocks processor stores to addresses 7600 to 7777 (field one if 8K); it blocks deposits there only with one field
// - guard refuses call, store-clear, increment-skip and input writes into that page
// - next-instruction pointer is shown as a 12-bit display value
// - address display shows the address of the word being read or written
// - buffer display shows the 12-bit word moving to or from memory
// - after deposit or examine the arithmetic display holds the addressed word
// - link is a one-bit extension of the arithmetic register and is displayed
`timescale 1ns/1ps

module operator_console_control
  import console_pkg::*;
#(
  parameter int FIELD_COUNT = 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire panel_t      panel_i,
  input  wire core_state_t core_i,
  input  wire core_wr_t    core_wr_i,
  input  wire logic [11:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  output mem_req_t         mem_o,
  output logic             run_o,
  output logic             clear_regs_o,
  output logic             ac_load_o,
  output logic      [11:0] ac_load_val_o,
  output logic      [11:0] pc_o,
  output logic      [11:0] ma_o,
  output logic      [11:0] mb_o,
  output logic      [11:0] ac_o,
  output logic             link_o,
  output logic             wr_verdict_o,
  output logic             wr_allowed_o
);

  localparam int PANEL_W = $bits(panel_t);

  if (FIELD_COUNT < 1 || FIELD_COUNT > 2) begin : g_bad_fields
    $error("FIELD_COUNT must be 1 or 2");
  end

  function automatic logic [11:0] next_addr(input logic [11:0] a);
    return a + ADDR_STEP;
  endfunction : next_addr

  function automatic logic in_guard(input logic [11:0] a, input logic field);
    logic hit;
    hit = (a >= GUARD_LO) && (a <= GUARD_HI);
    if (FIELD_COUNT == 2) begin
      hit = hit && (field == GUARD_FIELD);
    end
    return hit;
  endfunction : in_guard

  // panel synchroniser
  logic [PANEL_W-1:0] sync1_r;
  logic [PANEL_W-1:0] sync2_r;
  logic [PANEL_W-1:0] sync3_r;
  logic [PANEL_W-1:0] stable_r;
  logic [PANEL_W-1:0] agree;
  panel_t             pan;
  logic [KEY_W-1:0]   key_prev_r;
  logic [KEY_W-1:0]   soft_key_r;
  key_set_t           kp;
  logic               scyc_r;
  logic               sins_r;
  logic               guard_sw_r;
  logic               guard_on;

  // control state
  con_state_t         state_r;
  logic               stop_pend_r;
  logic               step_cyc_r;
  logic               step_ins_r;
  logic               dep_blocked_r;
  logic               guard_hit_r;
  logic [1:0]         ctrl_r;
  logic               do_start;
  logic               do_continue_key;
  logic               do_load;
  logic               do_dep;
  logic               do_examine_key;
  logic               dep_guarded;
  logic               dep_done;
  logic               examine_key_done;
  logic               halt_now;
  logic               wr_block;

  // bus
  logic               wb_req;
  logic               wb_wr;
  logic [31:0]        rd_data;

  assign agree = ~(sync2_r ^ sync3_r);
  assign pan   = panel_t'(stable_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= panel_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a bit only changes once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stable_r <= '0;
    end else begin
      stable_r <= (stable_r & ~agree) | (sync3_r & agree);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_prev_r <= '0;
    end else begin
      key_prev_r <= pan.keys;
    end
  end

  // rising edge of each key, or a software key, blocked under lockout
  always_comb begin
    kp = key_set_t'(((pan.keys & ~key_prev_r) | soft_key_r)
                    & {KEY_W{~pan.console_lockout}});
  end

  // mode switches freeze at their last value while locked out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scyc_r     <= 1'b0;
      sins_r     <= 1'b0;
      guard_sw_r <= 1'b0;
    end else if (!pan.console_lockout) begin
      scyc_r     <= pan.single_cycle_switch;
      sins_r     <= pan.single_instruction_switch;
      guard_sw_r <= pan.top_page_write_guard;
    end
  end

  assign guard_on = guard_sw_r | ctrl_r[CT_GUARD_BIT];

  // key decode, start first, only while halted
  always_comb begin
    do_start    = (state_r == ST_HALT) && kp.start;
    do_continue_key     = (state_r == ST_HALT) && !kp.start && kp.continue_key;
    do_load     = (state_r == ST_HALT) && !kp.start && !kp.continue_key && kp.load;
    do_dep      = (state_r == ST_HALT) && !kp.start && !kp.continue_key && !kp.load && kp.deposit;
    do_examine_key     = (state_r == ST_HALT) && !kp.start && !kp.continue_key && !kp.load && !kp.deposit
                  && kp.examine;
    dep_guarded = guard_on && in_guard(pc_o, 1'b0);
    dep_done    = (state_r == ST_DEP) && (dep_blocked_r || (mem_o.req && mem_ack_i));
    examine_key_done   = (state_r == ST_EXAMINE_KEY) && mem_o.req && mem_ack_i;
    halt_now    = (state_r == ST_RUN)
                  && ((step_cyc_r && core_i.mem_cycle_done)
                      || ((step_ins_r || stop_pend_r || kp.stop) && core_i.instr_done));
    wr_block    = core_wr_i.valid && guard_on && in_guard(core_wr_i.addr, core_wr_i.field);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_HALT;
    end else begin
      case (state_r)
        ST_HALT: begin
          if (do_start || do_continue_key) begin
            state_r <= ST_RUN;
          end else if (do_dep) begin
            state_r <= ST_DEP;
          end else if (do_examine_key) begin
            state_r <= ST_EXAMINE_KEY;
          end
        end
        ST_RUN: begin
          if (halt_now) begin
            state_r <= ST_HALT;
          end
        end
        ST_DEP: begin
          if (dep_done) begin
            state_r <= ST_HALT;
          end
        end
        ST_EXAMINE_KEY: begin
          if (examine_key_done) begin
            state_r <= ST_HALT;
          end
        end
        default: state_r <= ST_HALT;
      endcase
    end
  end

  // step mode taken when the run begins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_cyc_r  <= 1'b0;
      step_ins_r  <= 1'b0;
      stop_pend_r <= 1'b0;
    end else if (do_start || do_continue_key) begin
      step_cyc_r  <= scyc_r;
      step_ins_r  <= sins_r & ~scyc_r;
      stop_pend_r <= 1'b0;
    end else if (state_r == ST_RUN && kp.stop) begin
      stop_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_o        <= 1'b0;
      clear_regs_o <= 1'b0;
    end else begin
      clear_regs_o <= do_start;
      if (do_start || do_continue_key) begin
        run_o <= 1'b1;
      end else if (halt_now) begin
        run_o <= 1'b0;
      end
    end
  end

  // memory port for console transfers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_o         <= '0;
      dep_blocked_r <= 1'b0;
    end else if (do_dep) begin
      mem_o.req     <= ~dep_guarded;
      mem_o.we      <= 1'b1;
      mem_o.addr    <= pc_o;
      mem_o.wdata   <= pan.switch_word;
      dep_blocked_r <= dep_guarded;
    end else if (do_examine_key) begin
      mem_o.req     <= 1'b1;
      mem_o.we      <= 1'b0;
      mem_o.addr    <= pc_o;
      dep_blocked_r <= 1'b0;
    end else if (dep_done || examine_key_done) begin
      mem_o.req     <= 1'b0;
      mem_o.we      <= 1'b0;
      dep_blocked_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= PC_RST;
    end else if (do_load) begin
      pc_o <= pan.switch_word;
    end else if (dep_done || examine_key_done) begin
      pc_o <= next_addr(pc_o);
    end else if (state_r == ST_RUN) begin
      pc_o <= core_i.pc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ma_o <= WORD_RST;
    end else if (do_dep || do_examine_key) begin
      ma_o <= pc_o;
    end else if (state_r == ST_RUN) begin
      ma_o <= core_i.ma;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mb_o <= WORD_RST;
    end else if (do_start) begin
      mb_o <= WORD_RST;
    end else if (do_dep) begin
      mb_o <= pan.switch_word;
    end else if (examine_key_done) begin
      mb_o <= mem_rdata_i;
    end else if (state_r == ST_RUN) begin
      mb_o <= core_i.mb;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ac_o   <= WORD_RST;
      link_o <= 1'b0;
    end else if (do_start) begin
      ac_o   <= WORD_RST;
      link_o <= 1'b0;
    end else if (dep_done) begin
      ac_o   <= mb_o;
    end else if (examine_key_done) begin
      ac_o   <= mem_rdata_i;
    end else if (state_r == ST_RUN) begin
      ac_o   <= core_i.ac;
      link_o <= core_i.link;
    end
  end

  // push the shown word into the processor's arithmetic register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ac_load_o     <= 1'b0;
      ac_load_val_o <= WORD_RST;
    end else begin
      ac_load_o <= dep_done | examine_key_done;
      if (dep_done) begin
        ac_load_val_o <= mb_o;
      end else if (examine_key_done) begin
        ac_load_val_o <= mem_rdata_i;
      end
    end
  end

  // verdict on processor stores, one cycle after each request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_verdict_o <= 1'b0;
      wr_allowed_o <= 1'b0;
    end else begin
      wr_verdict_o <= core_wr_i.valid;
      wr_allowed_o <= core_wr_i.valid & ~wr_block;
    end
  end

  // bus slave, one wait-free acknowledge
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wb_wr && wb_adr_i == REG_CTRL) begin
      ctrl_r <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_key_r <= '0;
    end else if (wb_wr && wb_adr_i == REG_KEY && ctrl_r[CT_SOFT_BIT]) begin
      soft_key_r <= wb_dat_i[KEY_W-1:0];
    end else begin
      soft_key_r <= '0;
    end
  end

  // sticky guard hit, a new hit beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_hit_r <= 1'b0;
    end else if (wr_block || (do_dep && dep_guarded)) begin
      guard_hit_r <= 1'b1;
    end else if (wb_wr && wb_adr_i == REG_STATUS && wb_dat_i[ST_HIT_BIT]) begin
      guard_hit_r <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      REG_STATUS: begin
        rd_data[ST_RUN_BIT]   = run_o;
        rd_data[ST_LOCK_BIT]  = pan.console_lockout;
        rd_data[ST_GUARD_BIT] = guard_on;
        rd_data[ST_SCYC_BIT]  = scyc_r;
        rd_data[ST_SINS_BIT]  = sins_r;
        rd_data[ST_HIT_BIT]   = guard_hit_r;
      end
      REG_PC:     rd_data = {20'h00000, pc_o};
      REG_MA:     rd_data = {20'h00000, ma_o};
      REG_MB:     rd_data = {20'h00000, mb_o};
      REG_AC:     rd_data = {19'h00000, link_o, ac_o};
      REG_SWITCH: rd_data = {20'h00000, pan.switch_word};
      REG_CTRL:   rd_data = {30'h00000000, ctrl_r};
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

endmodule : operator_console_control

// ---- verification/operator_console_control_props.sv ----
// concurrent checks on the operator console ports
`timescale 1ns/1ps
module console_props_checker
  import console_pkg::*;
#(
  parameter int FIELD_COUNT = 1
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire core_state_t core_i,
  input wire core_wr_t    core_wr_i,
  input wire logic        mem_ack_i,
  input wire mem_req_t    mem_o,
  input wire logic        run_o,
  input wire logic        clear_regs_o,
  input wire logic        ac_load_o,
  input wire logic [11:0] ac_load_val_o,
  input wire logic [11:0] pc_o,
  input wire logic [11:0] ma_o,
  input wire logic [11:0] mb_o,
  input wire logic [11:0] ac_o,
  input wire logic        link_o,
  input wire logic        wr_verdict_o,
  input wire logic        wr_allowed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  start_clear_a: assert property (clear_regs_o |-> run_o && !$past(run_o)
    && ac_o == 12'h000 && !link_o ##1 !clear_regs_o) else $error("start pulse wrong");
  verdict_next_a: assert property (core_wr_i.valid |=> wr_verdict_o)
    else $error("no write verdict");
  guard_range_a: assert property (wr_verdict_o && !wr_allowed_o |->
    $past(core_wr_i.addr) >= GUARD_LO
    && (FIELD_COUNT == 1 || $past(core_wr_i.field) == GUARD_FIELD))
    else $error("write refused outside guarded page");
  req_hold_a: assert property (mem_o.req && !mem_ack_i |=> mem_o.req
    && $stable(mem_o.addr) && $stable(mem_o.we)) else $error("memory request dropped");
  req_addr_a: assert property (mem_o.req |-> ma_o == mem_o.addr
    && pc_o == mem_o.addr) else $error("address display wrong");
  dep_buffer_a: assert property (mem_o.req && mem_o.we |-> mem_o.wdata == mb_o)
    else $error("write data not from buffer");
  step_wrap_a: assert property (ac_load_o |-> pc_o == $past(pc_o) + ADDR_STEP)
    else $error("pointer step wrong");
  ac_copy_a: assert property (ac_load_o |-> ac_o == mb_o && ac_load_val_o == mb_o)
    else $error("arithmetic display wrong");
  halt_cause_a: assert property ($fell(run_o) |->
    $past(core_i.instr_done) || $past(core_i.mem_cycle_done)) else $error("halt too early");
endmodule : console_props_checker

bind operator_console_control console_props_checker #(.FIELD_COUNT(FIELD_COUNT)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .core_i(core_i), .core_wr_i(core_wr_i),
  .mem_ack_i(mem_ack_i), .mem_o(mem_o), .run_o(run_o), .clear_regs_o(clear_regs_o),
  .ac_load_o(ac_load_o), .ac_load_val_o(ac_load_val_o), .pc_o(pc_o), .ma_o(ma_o),
  .mb_o(mb_o), .ac_o(ac_o), .link_o(link_o), .wr_verdict_o(wr_verdict_o),
  .wr_allowed_o(wr_allowed_o));

// ---- verification/console_mem_model.sv ----
// memory partner answering console requests after a chosen delay
`timescale 1ns/1ps
module console_mem_model
  import console_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire mem_req_t    mem_i,
  input  wire logic [1:0]  dly_i,
  output logic      [11:0] rdata_o,
  output logic             ack_o
);
  logic [11:0] mem_r [4096];
  logic [1:0]  wait_r;

  initial begin
    foreach (mem_r[i]) mem_r[i] = WORD_RST;
  end

  always @(posedge clk_i) begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;  // data lines not held between answers
    if (rst_i) begin
      wait_r  <= 2'h0;
      rdata_o <= 12'h000;
    end else if (mem_i.req && !ack_o) begin
      if (wait_r == dly_i) begin
        ack_o  <= 1'b1;
        wait_r <= 2'h0;
        if (mem_i.we) mem_r[mem_i.addr] <= mem_i.wdata;
        else rdata_o <= mem_r[mem_i.addr];
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule : console_mem_model

// ---- verification/operator_console_control_tb_top.sv ----
// self-checking bench for the operator console
`timescale 1ns/1ps
module operator_console_control_tb_top;
  import console_pkg::*;
  typedef struct packed {
    logic [2:0]  key;
    logic [11:0] sw;
    logic [11:0] pc;
    logic [11:0] ma;
    logic [11:0] ac;
  } row_t;
  localparam int K_START = 5, K_LOAD = 4, K_DEP = 3, K_EXAMINE_KEY = 2, K_CONTINUE_KEY = 1, K_STOP = 0;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, mem_ack_i, run_o, clear_regs_o, link_o, wr_verdict_o, wr_allowed_o;
  logic [11:0] mem_rdata_i, pc_o, ma_o, mb_o, ac_o;
  logic [1:0]  dly = 2'h0;
  panel_t      panel_i = '0;
  core_state_t core_i = '0;
  core_wr_t    core_wr_i = '0;
  mem_req_t    mem_o;
  int          error_cnt = 0, num_checks = 0, cyc_cnt = 0, clr_cnt = 0;
  row_t rows [6] = '{'{3'h4, 12'hFFE, 12'hFFE, 12'h000, 12'h000},
                     '{3'h3, 12'h123, 12'hFFF, 12'hFFE, 12'h123},
                     '{3'h3, 12'h456, 12'h000, 12'hFFF, 12'h456},
                     '{3'h4, 12'hFFE, 12'hFFE, 12'hFFF, 12'h456},
                     '{3'h2, 12'h000, 12'hFFF, 12'hFFE, 12'h123},
                     '{3'h2, 12'h000, 12'h000, 12'hFFF, 12'h456}};

  operator_console_control #(.FIELD_COUNT(1)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .panel_i(panel_i), .core_i(core_i), .core_wr_i(core_wr_i), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i), .mem_o(mem_o), .run_o(run_o), .clear_regs_o(clear_regs_o),
    .ac_load_o(), .ac_load_val_o(), .pc_o(pc_o), .ma_o(ma_o), .mb_o(mb_o), .ac_o(ac_o),
    .link_o(link_o), .wr_verdict_o(wr_verdict_o), .wr_allowed_o(wr_allowed_o));
  console_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o), .dly_i(dly),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (clear_regs_o === 1'b1) clr_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb_xfer(input logic we, input logic [3:0] sel, input logic [7:0] adr,
                         input logic [31:0] dat);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, sel};
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // the acknowledge ends this wait; without one only the bench timeout ends it
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
    chk(wb_ack_o, 1'b0);
  endtask : wb_xfer

  // key held several cycles, then released and left to settle
  task automatic press(input int k, input logic [11:0] sw);
    @(posedge clk_i);
    panel_i.keys <= key_set_t'(6'h01 << k);
    panel_i.switch_word <= sw;
    repeat (6) @(posedge clk_i);
    panel_i.keys <= '0;
    repeat (16) @(posedge clk_i);
    #1;
  endtask : press

  task automatic pulse(input logic instr);
    @(posedge clk_i);
    {core_i.instr_done, core_i.mem_cycle_done} <= {instr, !instr};
    @(posedge clk_i);
    {core_i.instr_done, core_i.mem_cycle_done} <= 2'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : pulse

  task automatic probe(input int k, input logic [11:0] adr, input logic ok);
    @(posedge clk_i);
    core_wr_i <= {1'b1, k[1:0], 1'b1, adr};
    @(posedge clk_i);
    core_wr_i.valid <= 1'b0;
    #1;
    chk(wr_verdict_o, 1);
    chk(wr_allowed_o, ok);
  endtask : probe

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({run_o, pc_o, ma_o}, 0);
    chk({mb_o, ac_o}, 0);
    // loads are made only while halted
    foreach (rows[i]) begin
      dly <= 2'(i % 3);
      press(rows[i].key, rows[i].sw);
      chk(pc_o, rows[i].pc);
      chk(ma_o, rows[i].ma);
      chk(ac_o, rows[i].ac);
      chk(mb_o, rows[i].ac);
    end
    panel_i.top_page_write_guard <= 1'b1;
    press(K_LOAD, 12'hF7F);
    press(K_DEP, 12'hAAA);
    press(K_DEP, 12'h555);
    chk(pc_o, 12'hF81);
    wb_xfer(1'b0, 4'hF, REG_STATUS, 32'h0);
    chk(rd[5:2], 4'h9);
    press(K_LOAD, 12'hF7F);
    press(K_EXAMINE_KEY, 12'h000);
    chk(ac_o, 12'hAAA);
    press(K_EXAMINE_KEY, 12'h000);
    chk(ac_o, 12'h000);
    for (int k = 0; k < 8; k++) probe(k, k[2] ? 12'hF7F : 12'hF80, k[2]);
    panel_i.top_page_write_guard <= 1'b0;
    repeat (6) @(posedge clk_i);
    probe(0, 12'hFFF, 1'b1);
    wb_xfer(1'b1, 4'h0, REG_CTRL, 32'h3);
    wb_xfer(1'b0, 4'hF, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    wb_xfer(1'b1, 4'hF, REG_CTRL, 32'h3);
    probe(1, 12'hFFF, 1'b0);
    panel_i.switch_word <= 12'h321;
    // let the new switch word through the panel synchroniser
    repeat (6) @(posedge clk_i);
    wb_xfer(1'b1, 4'hF, REG_KEY, 32'h10);
    repeat (4) @(posedge clk_i);
    wb_xfer(1'b0, 4'hF, REG_PC, 32'h0);
    chk(rd, 32'h321);
    wb_xfer(1'b0, 4'hF, 8'h20, 32'h0);
    chk(rd, 32'h0);
    panel_i.console_lockout <= 1'b1;
    repeat (6) @(posedge clk_i);
    press(K_LOAD, 12'h777);
    press(K_START, 12'h777);
    chk({run_o, pc_o}, 13'h0321);
    panel_i.console_lockout <= 1'b0;
    repeat (6) @(posedge clk_i);
    press(K_START, 12'h000);
    chk(run_o, 1);
    press(K_STOP, 12'h000);
    chk(run_o, 1);
    pulse(1'b1);
    chk(run_o, 0);
    panel_i.single_cycle_switch <= 1'b1;
    press(K_CONTINUE_KEY, 12'h000);
    chk(run_o, 1);
    pulse(1'b0);
    chk(run_o, 0);
    {panel_i.single_cycle_switch, panel_i.single_instruction_switch} <= 2'h1;
    press(K_CONTINUE_KEY, 12'h000);
    pulse(1'b0);
    chk(run_o, 1);
    pulse(1'b1);
    chk(run_o, 0);
    chk(clr_cnt, 1);
    finish_test();
  end
endmodule : operator_console_control_tb_top
